// [src/pcp_card.sv]
// Card end of the host port: attribute status registers and lane steering
//
// Summary of operation
// R01 - Ready change sets flag; host may write
// R02 - Write-protect change sets flag; host may write
// R03 - Bit D1 reads internal ready state
// R04 - Live write-protect bit always reads zero
// R05 - Written D1 masks write of D5
// R06 - Written D0 masks write of D4
// R07 - Host writes reserved socket bit as zero
// R08 - Drive number bit reads back as written
// R09 - Host should write drive number zero
// R10 - Socket number field is ignored
// R11 - Host writes socket before configuration index
// R12 - Every I/O address accepts both widths
// R13 - Host splits word without wide acknowledge
// R14 - Card stretches input cycle; host extends
// R15 - I/O byte and word lane steering
// R16 - High-lane-only I/O moves odd byte
// R17 - Common memory steering, A0 ignored for words
// R18 - Float unselected lanes; attribute-high blocks I/O
// R19 - Change summary drives status pin
`timescale 1ns/1ps
`include "pcp_defines.svh"
module pcp_card #(
  parameter int ADDR_W = 11,
  parameter bit DRV_SUPPORTED = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  pcp_if.card bus,
  input wire logic ready_live,
  output logic cyc_req,
  output pcp_pkg::pcp_space_t cyc_space,
  output logic cyc_write,
  output logic [ADDR_W-1:0] cyc_addr,
  output logic [1:0] cyc_be,
  output logic [15:0] cyc_wdata,
  input wire logic [15:0] cyc_rdata,
  input wire logic cyc_rdy,
  output logic drive_num,
  output logic io_mode
);
  import pcp_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Byte enables for a lane pattern; bit 2 says the pattern is legal
  function automatic logic [2:0] lane_decode(input logic ce1_n, input logic ce2_n,
                                             input logic a0, input logic is_io);
    logic [2:0] r;
    r = 3'b000;
    if (!ce1_n && !ce2_n) begin
      r = {(is_io ? !a0 : 1'b1), 2'b11}; // R15 R17
    end else if (!ce1_n) begin
      r = {1'b1, (a0 ? 2'b10 : 2'b01)}; // R15
    end else if (!ce2_n) begin
      r = 3'b110; // R16
    end
    return r;
  endfunction

  // Attribute register hit
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [10:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [3:0] strb_prev_r, strb_prev_nxt;    // Strobes seen last cycle
  logic rdy_prev_r, rdy_prev_nxt;            // Ready level last cycle
  logic wp_prev_r, wp_prev_nxt;              // Write-protect level last cycle
  logic ready_change_flag_r, ready_change_flag_nxt;
  logic wp_change_flag_r, wp_change_flag_nxt;
  logic change_signal_enable_r, change_signal_enable_nxt;
  logic [5:0] cfg_idx_r, cfg_idx_nxt;        // Configuration index
  logic drive_select_bit_r, drive_select_bit_nxt;
  logic rd_busy_r, rd_busy_nxt;              // Read strobe in progress
  logic pend_r, pend_nxt;                    // Waiting on user data
  logic dvalid_r, dvalid_nxt;                // Read data on the pins
  logic [15:0] dout_r, dout_nxt;
  logic [1:0] doe_r, doe_nxt;
  logic cyc_req_r, cyc_req_nxt;
  pcp_space_t cyc_space_r, cyc_space_nxt;
  logic cyc_write_r, cyc_write_nxt;
  logic [ADDR_W-1:0] cyc_addr_r, cyc_addr_nxt;
  logic [1:0] cyc_be_r, cyc_be_nxt;
  logic [15:0] cyc_wdata_r, cyc_wdata_nxt;
  logic status_change_pin_n_n_r, status_change_pin_n_n_nxt;

  logic wp_live_state_src;   // No switch: never protected
  logic lanes_any;           // Either lane selected
  logic io_cfg;              // Configured for I/O
  logic [3:0] strb_now;      // mem rd, mem wr, io rd, io wr
  logic [3:0] strb_start;    // First cycle of each strobe
  logic [2:0] dec;           // Lane decode of current pins
  logic [7:0] reg_rd;        // Attribute read value
  logic low_odd;             // Low lane only, odd address

  assign wp_live_state_src = 1'b0; // R04
  assign lanes_any = !bus.low_lane_sel_n || !bus.high_lane_sel_n; // R18
  assign io_cfg = cfg_idx_r != 6'h00;
  assign low_odd = !bus.low_lane_sel_n && bus.high_lane_sel_n && bus.addr[0];

  // ****************************************
  // Pin decode
  // ****************************************
  // Combinational strobe and register read decode
  always_comb begin
    strb_now[0] = !bus.mem_read_strobe_n && lanes_any;
    strb_now[1] = !bus.mem_write_strobe_n && lanes_any;
    // I/O strobes count only with attribute select low and I/O configured
    strb_now[2] = !bus.io_read_strobe_n && !bus.attr_sel_n && lanes_any && io_cfg; // R18
    strb_now[3] = !bus.io_write_strobe_n && !bus.attr_sel_n && lanes_any && io_cfg; // R18
    strb_start = strb_now & ~strb_prev_r;
    dec = lane_decode(bus.low_lane_sel_n, bus.high_lane_sel_n, bus.addr[0], strb_now[2] | strb_now[3]);
    reg_rd = 8'h00;
    if (reg_hit(bus.addr, `PCP_OFS_CFG_OPT)) begin
      reg_rd = {2'b00, cfg_idx_r};
    end else if (reg_hit(bus.addr, `PCP_OFS_CFG_STAT)) begin
      reg_rd[`PCP_CS_CHANGED] = ready_change_flag_r | wp_change_flag_r; // R19
      reg_rd[`PCP_CS_CHANGE_SIGNAL_ENABLE] = change_signal_enable_r;
    end else if (reg_hit(bus.addr, `PCP_OFS_PIN_REP)) begin
      reg_rd = 8'h0C;
      reg_rd[`PCP_PR_RDY_CHG] = ready_change_flag_r;
      reg_rd[`PCP_PR_WP_CHG] = wp_change_flag_r;
      reg_rd[`PCP_PR_RDY] = ready_live; // R03
      reg_rd[`PCP_PR_WP] = 1'b0; // R04
    end else if (reg_hit(bus.addr, `PCP_OFS_SOCK_COPY)) begin
      // Reserved and socket number bits read as zero
      reg_rd[`PCP_SC_DRV] = drive_select_bit_r; // R08 R10
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  // Register writes, change flags, read pipeline and user requests
  always_comb begin
    strb_prev_nxt = strb_now;
    rdy_prev_nxt = ready_live;
    wp_prev_nxt = wp_live_state_src;
    ready_change_flag_nxt = ready_change_flag_r;
    wp_change_flag_nxt = wp_change_flag_r;
    change_signal_enable_nxt = change_signal_enable_r;
    cfg_idx_nxt = cfg_idx_r;
    drive_select_bit_nxt = drive_select_bit_r;
    rd_busy_nxt = rd_busy_r;
    pend_nxt = pend_r;
    dvalid_nxt = dvalid_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    cyc_req_nxt = 1'b0;
    cyc_space_nxt = cyc_space_r;
    cyc_write_nxt = cyc_write_r;
    cyc_addr_nxt = cyc_addr_r;
    cyc_be_nxt = cyc_be_r;
    cyc_wdata_nxt = cyc_wdata_r;
    // Attribute write: low lane, even byte on D7-D0
    if (strb_start[1] && !bus.attr_sel_n) begin
      if (reg_hit(bus.addr, `PCP_OFS_CFG_OPT)) begin
        cfg_idx_nxt = bus.data[`PCP_CO_IDX_MSB:0];
      end else if (reg_hit(bus.addr, `PCP_OFS_CFG_STAT)) begin
        change_signal_enable_nxt = bus.data[`PCP_CS_CHANGE_SIGNAL_ENABLE];
      end else if (reg_hit(bus.addr, `PCP_OFS_PIN_REP)) begin
        if (bus.data[`PCP_PR_RDY]) begin
          ready_change_flag_nxt = bus.data[`PCP_PR_RDY_CHG]; // R05
        end
        if (bus.data[`PCP_PR_WP]) begin
          wp_change_flag_nxt = bus.data[`PCP_PR_WP_CHG]; // R06
        end
      end else if (reg_hit(bus.addr, `PCP_OFS_SOCK_COPY)) begin
        // Socket number bits D3-D0 are dropped
        drive_select_bit_nxt = DRV_SUPPORTED & bus.data[`PCP_SC_DRV]; // R08 R10
      end
    end else if ((strb_start[1] || strb_start[3]) && dec[2]) begin
      // Common memory or I/O write handed to the user side
      cyc_req_nxt = 1'b1;
      cyc_space_nxt = strb_start[3] ? PCP_SP_IO : PCP_SP_MEM;
      cyc_write_nxt = 1'b1;
      cyc_addr_nxt = bus.addr;
      cyc_be_nxt = dec[1:0]; // R12
      cyc_wdata_nxt = low_odd ? {bus.data[7:0], 8'h00} : bus.data; // R15 R17
    end
    // Live level changes set the flags; an event beats a same-cycle clear
    if (ready_live != rdy_prev_r) begin
      ready_change_flag_nxt = 1'b1; // R01
    end
    if (wp_live_state_src != wp_prev_r) begin
      wp_change_flag_nxt = 1'b1; // R02
    end
    // Read start
    if (strb_start[0] || strb_start[2]) begin
      rd_busy_nxt = 1'b1;
      if (strb_start[0] && !bus.attr_sel_n) begin
        dout_nxt = {8'h00, reg_rd};
        doe_nxt = {1'b0, !bus.low_lane_sel_n};
        dvalid_nxt = 1'b1;
      end else if (dec[2]) begin
        cyc_req_nxt = 1'b1;
        cyc_space_nxt = strb_start[2] ? PCP_SP_IO : PCP_SP_MEM;
        cyc_write_nxt = 1'b0;
        cyc_addr_nxt = bus.addr;
        cyc_be_nxt = dec[1:0]; // R12
        pend_nxt = 1'b1;
      end else begin
        // Illegal lane pattern: release the wait, drive nothing
        dvalid_nxt = 1'b1;
        doe_nxt = 2'b00;
      end
    end else if (pend_r && cyc_rdy) begin
      // Odd byte goes to D7-D0 on a low-lane odd read
      dout_nxt = {cyc_rdata[15:8], low_odd ? cyc_rdata[15:8] : cyc_rdata[7:0]}; // R15 R17
      doe_nxt = {!bus.high_lane_sel_n, !bus.low_lane_sel_n}; // R16 R18
      dvalid_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
    // Strobe released: float and forget; late user data is dropped
    if (rd_busy_r && !(strb_now[0] || strb_now[2])) begin
      rd_busy_nxt = 1'b0;
      pend_nxt = 1'b0;
      dvalid_nxt = 1'b0;
      doe_nxt = 2'b00; // R18
    end
    status_change_pin_n_n_nxt = !((ready_change_flag_r | wp_change_flag_r) && change_signal_enable_r && io_cfg); // R19
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous active-low reset to idle, unconfigured
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      strb_prev_r <= 4'h0;
      rdy_prev_r <= 1'b0;
      wp_prev_r <= 1'b0;
      ready_change_flag_r <= 1'b0;
      wp_change_flag_r <= 1'b0;
      change_signal_enable_r <= 1'b0;
      cfg_idx_r <= `PCP_CFG_IDX_RST;
      drive_select_bit_r <= 1'b0;
      rd_busy_r <= 1'b0;
      pend_r <= 1'b0;
      dvalid_r <= 1'b0;
      dout_r <= 16'h0000;
      doe_r <= 2'b00;
      cyc_req_r <= 1'b0;
      cyc_space_r <= PCP_SP_ATTR;
      cyc_write_r <= 1'b0;
      cyc_addr_r <= '0;
      cyc_be_r <= 2'b00;
      cyc_wdata_r <= 16'h0000;
      status_change_pin_n_n_r <= 1'b1;
    end else begin
      strb_prev_r <= strb_prev_nxt;
      rdy_prev_r <= rdy_prev_nxt;
      wp_prev_r <= wp_prev_nxt;
      ready_change_flag_r <= ready_change_flag_nxt;
      wp_change_flag_r <= wp_change_flag_nxt;
      change_signal_enable_r <= change_signal_enable_nxt;
      cfg_idx_r <= cfg_idx_nxt;
      drive_select_bit_r <= drive_select_bit_nxt;
      rd_busy_r <= rd_busy_nxt;
      pend_r <= pend_nxt;
      dvalid_r <= dvalid_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      cyc_req_r <= cyc_req_nxt;
      cyc_space_r <= cyc_space_nxt;
      cyc_write_r <= cyc_write_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      cyc_be_r <= cyc_be_nxt;
      cyc_wdata_r <= cyc_wdata_nxt;
      status_change_pin_n_n_r <= status_change_pin_n_n_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.card_d_o = dout_r;
  assign bus.card_d_oe = doe_r;
  // Wait from the first strobe cycle until data is on the pins
  assign bus.wait_n = !((strb_now[0] || strb_now[2]) && !dvalid_r); // R14
  // Every decoded I/O address is word capable
  assign bus.wide_port_ack_n = !(!bus.attr_sel_n && io_cfg && lanes_any); // R12
  assign bus.status_change_pin_n = status_change_pin_n_n_r; // R19
  assign cyc_req = cyc_req_r;
  assign cyc_space = cyc_space_r;
  assign cyc_write = cyc_write_r;
  assign cyc_addr = cyc_addr_r;
  assign cyc_be = cyc_be_r;
  assign cyc_wdata = cyc_wdata_r;
  assign drive_num = drive_select_bit_r;
  assign io_mode = io_cfg;
endmodule

// [common/pcp_defines.svh]
// Offsets, bit positions and timing counts for the card host port
`ifndef PCP_DEFINES_SVH
`define PCP_DEFINES_SVH
// ****************************************
// Attribute register offsets
// ****************************************
`define PCP_OFS_CFG_OPT 11'h000
`define PCP_OFS_CFG_STAT 11'h002
`define PCP_OFS_PIN_REP 11'h004
`define PCP_OFS_SOCK_COPY 11'h006
// ****************************************
// Field positions
// ****************************************
`define PCP_PR_RDY_CHG 5
`define PCP_PR_WP_CHG 4
`define PCP_PR_RDY 1
`define PCP_PR_WP 0
`define PCP_CS_CHANGED 7
`define PCP_CS_CHANGE_SIGNAL_ENABLE 6
`define PCP_SC_RSVD 7
`define PCP_SC_DRV 4
`define PCP_CO_IDX_MSB 5
// ****************************************
// Reset values
// ****************************************
`define PCP_CFG_IDX_RST 6'h00
// ****************************************
// Timing
// ****************************************
`define PCP_CLK_NS 10
`define PCP_STROBE_NS 30
`define PCP_STROBE_CYC ((`PCP_STROBE_NS + `PCP_CLK_NS - 1) / `PCP_CLK_NS)
`endif

// [common/pcp_pkg.sv]
// Shared types of the card host port
package pcp_pkg;
  // Address space of a cycle
  typedef enum logic [1:0] {
    PCP_SP_ATTR = 2'b00,
    PCP_SP_MEM = 2'b01,
    PCP_SP_IO = 2'b10
  } pcp_space_t;
  // Host sequencer states
  typedef enum logic [2:0] {
    PCP_H_IDLE = 3'b000,
    PCP_H_SETUP = 3'b001,
    PCP_H_STROBE = 3'b010,
    PCP_H_HOLD = 3'b011,
    PCP_H_DONE = 3'b100
  } pcp_hstate_t;
endpackage

// [common/pcp_if.sv]
// Socket pins joining the host adapter and the card
`timescale 1ns/1ps
interface pcp_if #(parameter int ADDR_W = 11);
  logic [ADDR_W-1:0] addr;      // Address from host
  logic attr_sel_n;             // Attribute select, low for attribute and I/O
  logic low_lane_sel_n;         // Low lane select
  logic high_lane_sel_n;        // High lane select
  logic mem_read_strobe_n;      // Memory read strobe
  logic mem_write_strobe_n;     // Memory write strobe
  logic io_read_strobe_n;       // I/O read strobe
  logic io_write_strobe_n;      // I/O write strobe
  logic [15:0] host_d_o;        // Host data out
  logic [1:0] host_d_oe;        // Host lane enables
  logic [15:0] card_d_o;        // Card data out
  logic [1:0] card_d_oe;        // Card lane enables
  logic [15:0] data;            // Resolved data bus
  logic wait_n;                 // Cycle stretch from card
  logic wide_port_ack_n;        // 16-bit port indication
  logic status_change_pin_n;    // Status change pin
  // Per lane wire level; a floating lane reads as zero
  assign data[7:0] = card_d_oe[0] ? card_d_o[7:0] : (host_d_oe[0] ? host_d_o[7:0] : 8'h00);
  assign data[15:8] = card_d_oe[1] ? card_d_o[15:8] : (host_d_oe[1] ? host_d_o[15:8] : 8'h00);
  modport card (input addr, attr_sel_n, low_lane_sel_n, high_lane_sel_n, mem_read_strobe_n,
    mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n, data,
    output card_d_o, card_d_oe, wait_n, wide_port_ack_n, status_change_pin_n);
  modport host (output addr, attr_sel_n, low_lane_sel_n, high_lane_sel_n, mem_read_strobe_n,
    mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n, host_d_o, host_d_oe,
    input data, wait_n, wide_port_ack_n, status_change_pin_n);
endinterface

// [src/pcp_host.sv]
// Host adapter end of the port: runs attribute, memory and I/O cycles
`timescale 1ns/1ps
`include "pcp_defines.svh"
module pcp_host #(
  parameter int ADDR_W = 11,
  parameter bit DRV_ZERO = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  pcp_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pcp_pkg::pcp_space_t cmd_space,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [1:0] cmd_be,
  input wire logic [15:0] cmd_wdata,
  output logic resp_valid,
  output logic [15:0] resp_rdata
);
  import pcp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  pcp_hstate_t st_r, st_nxt;
  pcp_space_t sp_r, sp_nxt;              // Space of current cycle
  logic wr_r, wr_nxt;                    // Write cycle
  logic [15:0] wd_r, wd_nxt;             // Write word
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic attr_n_r, attr_n_nxt;
  logic ce1_n_r, ce1_n_nxt;
  logic ce2_n_r, ce2_n_nxt;
  logic strobe_r, strobe_nxt;            // Strobe asserted
  logic split_r, split_nxt;              // Odd byte still to send
  logic [3:0] cnt_r, cnt_nxt;            // Strobe width counter
  logic [15:0] rd_r, rd_nxt;
  logic resp_r, resp_nxt;
  logic sock_done_r, sock_done_nxt;      // Socket register written
  logic inject;                          // Socket write goes first

  localparam logic [3:0] STROBE_CYC = 4'(`PCP_STROBE_CYC);

  // Socket register must precede the configuration index
  assign inject = cmd_valid && cmd_write && cmd_space == PCP_SP_ATTR
                  && cmd_addr == ADDR_W'(`PCP_OFS_CFG_OPT) && !sock_done_r; // R11
  assign cmd_ready = st_r == PCP_H_IDLE && !inject;

  // ****************************************
  // Sequencer
  // ****************************************
  // Setup, strobe, hold; I/O words split when the card gives no wide acknowledge
  always_comb begin
    st_nxt = st_r;
    sp_nxt = sp_r;
    wr_nxt = wr_r;
    wd_nxt = wd_r;
    addr_nxt = addr_r;
    attr_n_nxt = attr_n_r;
    ce1_n_nxt = ce1_n_r;
    ce2_n_nxt = ce2_n_r;
    strobe_nxt = strobe_r;
    split_nxt = split_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    resp_nxt = 1'b0;
    sock_done_nxt = sock_done_r;
    case (st_r)
      PCP_H_IDLE: begin
        cnt_nxt = 4'h0;
        split_nxt = 1'b0;
        rd_nxt = 16'h0000;
        if (inject) begin
          // Drive number and reserved bit written as zero
          sp_nxt = PCP_SP_ATTR;
          wr_nxt = 1'b1;
          wd_nxt = 16'h0000; // R07 R09
          addr_nxt = ADDR_W'(`PCP_OFS_SOCK_COPY);
          sock_done_nxt = 1'b1; // R11
          attr_n_nxt = 1'b0;
          ce1_n_nxt = 1'b0;
          ce2_n_nxt = 1'b1;
          st_nxt = PCP_H_SETUP;
        end else if (cmd_valid) begin
          sp_nxt = cmd_space;
          wr_nxt = cmd_write;
          wd_nxt = cmd_wdata;
          if (cmd_space == PCP_SP_ATTR && cmd_addr == ADDR_W'(`PCP_OFS_SOCK_COPY)) begin
            wd_nxt[`PCP_SC_RSVD] = 1'b0; // R07
            if (DRV_ZERO) begin
              wd_nxt[`PCP_SC_DRV] = 1'b0; // R09
            end
            // A read must not undo an earlier socket write
            sock_done_nxt = sock_done_r | cmd_write; // R11
          end
          // Attribute select is high only for common memory
          attr_n_nxt = cmd_space == PCP_SP_MEM; // R15 R17
          // Word: both lanes, even address; odd only: high lane
          addr_nxt = {cmd_addr[ADDR_W-1:1], 1'b0};
          ce1_n_nxt = cmd_space != PCP_SP_ATTR && cmd_be == 2'b10;
          ce2_n_nxt = cmd_space == PCP_SP_ATTR || cmd_be == 2'b01;
          st_nxt = PCP_H_SETUP;
        end
      end
      PCP_H_SETUP: begin
        // No wide acknowledge on a word: even byte now, odd byte after
        if (sp_r == PCP_SP_IO && !ce1_n_r && !ce2_n_r && bus.wide_port_ack_n) begin
          ce2_n_nxt = 1'b1; // R13
          split_nxt = 1'b1; // R13
        end
        strobe_nxt = 1'b1;
        cnt_nxt = 4'h1;
        st_nxt = PCP_H_STROBE;
      end
      PCP_H_STROBE: begin
        if (cnt_r < STROBE_CYC) begin
          cnt_nxt = cnt_r + 4'h1;
        end
        // Held past the width while the card stretches the cycle
        if (cnt_r >= STROBE_CYC && bus.wait_n) begin // R14
          strobe_nxt = 1'b0;
          st_nxt = PCP_H_HOLD;
          if (!wr_r) begin
            if (!ce1_n_r && !ce2_n_r) begin
              rd_nxt = bus.data;
            end else if (!ce2_n_r) begin
              rd_nxt[15:8] = bus.data[15:8];
            end else if (addr_r[0]) begin
              rd_nxt[15:8] = bus.data[7:0];
            end else begin
              rd_nxt[7:0] = bus.data[7:0];
            end
          end
        end
      end
      PCP_H_HOLD: begin
        if (split_r) begin
          addr_nxt = {addr_r[ADDR_W-1:1], 1'b1}; // R13
          split_nxt = 1'b0;
          st_nxt = PCP_H_SETUP;
        end else begin
          attr_n_nxt = 1'b1;
          ce1_n_nxt = 1'b1;
          ce2_n_nxt = 1'b1;
          st_nxt = PCP_H_DONE;
        end
      end
      PCP_H_DONE: begin
        resp_nxt = 1'b1;
        st_nxt = PCP_H_IDLE;
      end
      default: begin
        st_nxt = PCP_H_IDLE;
      end
    endcase
  end

  // Synchronous active-low reset to an idle socket
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= PCP_H_IDLE;
      sp_r <= PCP_SP_ATTR;
      wr_r <= 1'b0;
      wd_r <= 16'h0000;
      addr_r <= '0;
      attr_n_r <= 1'b1;
      ce1_n_r <= 1'b1;
      ce2_n_r <= 1'b1;
      strobe_r <= 1'b0;
      split_r <= 1'b0;
      cnt_r <= 4'h0;
      rd_r <= 16'h0000;
      resp_r <= 1'b0;
      sock_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sp_r <= sp_nxt;
      wr_r <= wr_nxt;
      wd_r <= wd_nxt;
      addr_r <= addr_nxt;
      attr_n_r <= attr_n_nxt;
      ce1_n_r <= ce1_n_nxt;
      ce2_n_r <= ce2_n_nxt;
      strobe_r <= strobe_nxt;
      split_r <= split_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      resp_r <= resp_nxt;
      sock_done_r <= sock_done_nxt;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign bus.addr = addr_r;
  assign bus.attr_sel_n = attr_n_r;
  assign bus.low_lane_sel_n = ce1_n_r;
  assign bus.high_lane_sel_n = ce2_n_r;
  assign bus.mem_read_strobe_n = !(strobe_r && sp_r != PCP_SP_IO && !wr_r);
  assign bus.mem_write_strobe_n = !(strobe_r && sp_r != PCP_SP_IO && wr_r);
  assign bus.io_read_strobe_n = !(strobe_r && sp_r == PCP_SP_IO && !wr_r);
  assign bus.io_write_strobe_n = !(strobe_r && sp_r == PCP_SP_IO && wr_r);
  // Odd byte of a split word rides the low lane
  assign bus.host_d_o = (!ce1_n_r && ce2_n_r && addr_r[0]) ? {8'h00, wd_r[15:8]} : wd_r;
  assign bus.host_d_oe = (wr_r && st_r != PCP_H_IDLE && st_r != PCP_H_DONE) ? {!ce2_n_r, !ce1_n_r} : 2'b00;
  assign resp_valid = resp_r;
  assign resp_rdata = rd_r;
endmodule

// [tb/pcp_checker.sv]
// Pin-level assertions between the host and card ends
`timescale 1ns/1ps
module pcp_checker (
  input logic ref_clk,
  input logic rstn,
  input logic low_lane_sel_n,
  input logic high_lane_sel_n,
  input logic mem_read_strobe_n,
  input logic io_read_strobe_n,
  input logic [1:0] card_d_oe,
  input logic wait_n,
  input logic status_change_pin_n
);
  // ****
  // Socket pin relations, all in one domain
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Two cycles give the registered lane enables time to drop
  lane_float_a: assert property ((low_lane_sel_n && high_lane_sel_n) [*2] |-> card_d_oe == 2'b00)
    else $error("card drives lanes while deselected");
  high_only_a: assert property ((low_lane_sel_n && !high_lane_sel_n) [*2] |-> !card_d_oe[0])
    else $error("low lane driven on high lane cycle");
  wait_read_a: assert property (!wait_n |-> !io_read_strobe_n || !mem_read_strobe_n)
    else $error("wait outside an input cycle");
  wait_bound_a: assert property ($fell(wait_n) |-> ##[1:20] wait_n)
    else $error("wait held too long");
  host_hold_a: assert property (!wait_n |=> $stable(io_read_strobe_n) && $stable(mem_read_strobe_n))
    else $error("host ended strobe during wait");
  oe_cause_a: assert property (card_d_oe != 2'b00 |-> !$past(io_read_strobe_n) || !$past(mem_read_strobe_n))
    else $error("card drove data without a read");
  reset_idle_a: assert property ($rose(rstn) |-> status_change_pin_n && wait_n && card_d_oe == 2'b00)
    else $error("pins not idle after reset");
  mem_wait_a: assert property ($fell(mem_read_strobe_n) |-> !wait_n)
    else $error("no wait at read start");
endmodule

// [tb/pcp_tb_top.sv]
// Bench joining host and card ends of the port
`timescale 1ns/1ps
module pcp_tb_top;
  import pcp_pkg::*;
  // ****
  // Stimulus and ends
  // ****
  localparam logic [15:0] RDAT = 16'hC3A5; // User side read word
  logic ref_clk = 1'b0, rstn = 1'b0, ready_live = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, cyc_rdy = 1'b0;
  logic cmd_ready, resp_valid, cyc_req, cyc_write, drive_num, io_mode;
  pcp_space_t cmd_space = PCP_SP_ATTR, cyc_space;
  logic [10:0] cmd_addr = 11'h000, cyc_addr;
  logic [1:0] cmd_be = 2'b01, cyc_be;
  logic [15:0] cmd_wdata = 16'h0000, resp_rdata, cyc_wdata;
  int miscompares = 0, n_tests = 0, n_req = 0, m;
  pcp_if u_bus ();
  pcp_card u_pcp_card (.ref_clk, .rstn, .bus(u_bus), .ready_live, .cyc_req, .cyc_space, .cyc_write, .cyc_addr,
    .cyc_be, .cyc_wdata, .cyc_rdata(RDAT), .cyc_rdy, .drive_num, .io_mode);
  pcp_host #(.DRV_ZERO(1'b0)) u_pcp_host (.ref_clk, .rstn, .bus(u_bus), .cmd_valid, .cmd_ready, .cmd_space,
    .cmd_write, .cmd_addr, .cmd_be, .cmd_wdata, .resp_valid, .resp_rdata);
  pcp_checker u_pcp_checker (.ref_clk, .rstn, .low_lane_sel_n(u_bus.low_lane_sel_n),
    .high_lane_sel_n(u_bus.high_lane_sel_n), .mem_read_strobe_n(u_bus.mem_read_strobe_n),
    .io_read_strobe_n(u_bus.io_read_strobe_n), .card_d_oe(u_bus.card_d_oe), .wait_n(u_bus.wait_n),
    .status_change_pin_n(u_bus.status_change_pin_n));
  initial forever #5 ref_clk = ~ref_clk;
  // User side answers each read one cycle later and counts requests
  always @(negedge ref_clk) begin
    cyc_rdy <= cyc_req & ~cyc_write;
    if (cyc_req) n_req++;
  end
  task chk(string n, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // One host command, bounded so a stuck handshake cannot hang the run
  task cmd(pcp_space_t s, logic w, logic [10:0] a, logic [1:0] b, logic [15:0] d);
    int k;
    k = 0;
    @(negedge ref_clk);
    cmd_space = s;
    cmd_write = w;
    cmd_addr = a;
    cmd_be = b;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    #1;
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && k < 90) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 90) chk("cmd_done", 16'h0001, 16'h0000);
  endtask
  task wr_rd(logic [10:0] a, logic [7:0] w, logic [7:0] e);
    cmd(PCP_SP_ATTR, 1'b1, a, 2'b01, {8'h00, w});
    cmd(PCP_SP_ATTR, 1'b0, a, 2'b01, 16'h0000);
    chk("attr_reg", {8'h00, e}, {8'h00, resp_rdata[7:0]});
  endtask
  task t_flags;
    ready_live = 1'b1;
    cmd(PCP_SP_ATTR, 1'b0, 11'h002, 2'b01, 16'h0000);
    chk("changed", 16'h0080, resp_rdata & 16'h0080);
    wr_rd(11'h004, 8'h01, 8'h2E);
    wr_rd(11'h004, 8'h12, 8'h0E);
    wr_rd(11'h004, 8'h11, 8'h1E);
    $display("t_flags done");
  endtask
  task t_sock;
    wr_rd(11'h006, 8'h1F, 8'h10);
    chk("drive_num", 16'h0001, {15'h0000, drive_num});
    $display("t_sock done");
  endtask
  task t_io;
    m = n_req;
    cmd(PCP_SP_IO, 1'b0, 11'h010, 2'b11, 16'h0000);
    chk("io_unconf", 16'h0000, resp_rdata | 16'(n_req - m));
    cmd(PCP_SP_ATTR, 1'b1, 11'h000, 2'b01, 16'h0001);
    chk("io_mode_drv", 16'h0003, {14'h0000, io_mode, drive_num});
    cmd(PCP_SP_ATTR, 1'b1, 11'h002, 2'b01, 16'h0040);
    chk("status_change_pin_n_pin", 16'h0000, {15'h0000, u_bus.status_change_pin_n});
    cmd(PCP_SP_IO, 1'b1, 11'h010, 2'b11, 16'h1234);
    chk("io_wr", 16'h1234, cyc_wdata);
    chk("io_ctl", 16'h0017, 16'({cyc_space, cyc_write, cyc_be}));
    chk("io_addr", 16'h0010, 16'(cyc_addr));
    m = n_req;
    cmd(PCP_SP_IO, 1'b0, 11'h010, 2'b11, 16'h0000);
    chk("io_rd", RDAT, resp_rdata);
    chk("io_once", 16'h0001, 16'(n_req - m));
    cmd(PCP_SP_IO, 1'b0, 11'h010, 2'b01, 16'h0000);
    chk("io_even", 16'h0001, {14'h0000, cyc_be});
    cmd(PCP_SP_IO, 1'b0, 11'h010, 2'b10, 16'h0000);
    chk("io_high", {RDAT[15:8], 8'h00}, resp_rdata & 16'hFF00);
    $display("t_io done");
  endtask
  task t_mem;
    cmd(PCP_SP_MEM, 1'b1, 11'h011, 2'b11, 16'hBEEF);
    chk("mem_ctl", 16'h000F, 16'({cyc_space, cyc_write, cyc_be}));
    cmd(PCP_SP_MEM, 1'b0, 11'h011, 2'b11, 16'h0000);
    chk("mem_rd", RDAT, resp_rdata);
    $display("t_mem done");
  endtask
  task print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    t_flags;
    t_sock;
    t_io;
    t_mem;
    print_verdict;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
endmodule
